//--- include/iox_pkg.sv
// constants of the i2c target transaction block of a 16-bit port expander
// assumes scl and sda arrive as open-drain lines resolved by the surroundings
//
// Contract
// R1: write: address+0, command byte, data, stop
// R2: read: command write, restart, address+1, data
// R3: controller acks each read byte, nacks last
// R4: nack reads until a command byte arrives
// R5: restart read uses register just addressed
// R6: load transmit byte on ack clock rise
// R7: same edge toggles pointer within pair
// R8: restart mid-read keeps toggled pointer
// R9: unlimited read bytes, alternating in pair
// R10: stop anytime; last acknowledged data stands
// R11: preset pointer lets reads skip command byte
// R12: address 11101 plus two select pins
// R13: three command bits pick one of eight
// R14: command byte persists as read pointer
// R15: each written byte toggles pointer in pair
// R16: start or stop drops partial byte
package iox_pkg;
	// target address upper bits, then two select pins
	localparam logic [4:0] ADDR_FIXED = 5'h1d;
	localparam int ADDR_FIXED_W = 5;
	// direction bit values
	localparam logic RW_READ = 1'h1;
	localparam logic RW_WRITE = 1'h0;
	// register pointer width and power-on value
	localparam int PTR_W = 3;
	localparam logic [2:0] PTR_RESET = 3'h0;
	// bit count of the ninth (acknowledge) clock of a byte
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST = 4'h7;
	// synchroniser depth for pins and link events
	localparam int SYNC_STAGES = 2;
	// transaction states, one-hot
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_CMD = 6'h04,
		ST_WDATA = 6'h08,
		ST_RDATA = 6'h10,
		ST_IGNORE = 6'h20
	} iox_state_e;
endpackage

//--- hw/iox_sync.sv
// multi-bit level synchroniser, one chain of flip-flops per bit
// assumes each bit is an independent level or a slow toggle
`timescale 1ns/1ps
`default_nettype none
module iox_sync #(
	parameter int WIDTH = 1,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage_q [STAGES];

	// elaboration check: fewer than two stages is no synchroniser
	if (STAGES < 2) begin : g_bad_stages
		$error("iox_sync needs at least two stages");
	end

	// first stage feeds only the next stage
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_q[i] <= '0;
			end
		end else begin
			stage_q[0] <= d;
			for (int i = 1; i < STAGES; i++) begin
				stage_q[i] <= stage_q[i-1];
			end
		end
	end

	assign q = stage_q[STAGES-1];
endmodule
`default_nettype wire

//--- hw/iox_i2c_target.sv
// i2c target transaction logic: address match, command pointer,
// write strobes and read data with pair alternation
// assumes a register file that answers REG_RD_DATA combinationally
// from REG_PTR, and an outside buffer resolving SDA from SDA_OE
`timescale 1ns/1ps
`default_nettype none
module iox_i2c_target (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic SCL_CLK,
	input wire logic SDA_I,
	output logic SDA_O,
	output logic SDA_OE,
	input wire logic ADDR_SELECT_LOW,
	input wire logic ADDR_SELECT_HIGH,
	output logic [2:0] REG_PTR,
	output logic REG_WR_STB,
	output logic [7:0] REG_WR_DATA,
	output logic REG_RD_STB,
	input wire logic [7:0] REG_RD_DATA,
	output logic CMD_VALID
);
	// link domain: sample sda on each scl rise, flag it by a toggle
	logic link_bit_q;
	logic link_tgl_q;

	// the bit is held a full scl period, so the core reads it after
	// the toggle has crossed, never while it can change
	always_ff @(posedge SCL_CLK or posedge RST) begin
		if (RST) begin
			link_bit_q <= 1'h0;
			link_tgl_q <= 1'h0;
		end else begin
			link_bit_q <= SDA_I;
			link_tgl_q <= ~link_tgl_q;
		end
	end

	// core domain synchronisers: scl, sda, toggle and select pins
	logic [4:0] sync_in;
	logic [4:0] sync_out;
	assign sync_in = {ADDR_SELECT_HIGH, ADDR_SELECT_LOW, link_tgl_q, SDA_I, SCL_CLK};

	iox_sync #(
		.WIDTH(5),
		.STAGES(iox_pkg::SYNC_STAGES)
	) u_sync (
		.clk(REF_CLK),
		.rst(RST),
		.d(sync_in),
		.q(sync_out)
	);

	wire scl_s = sync_out[0];
	wire sda_s = sync_out[1];
	wire tgl_s = sync_out[2];
	wire [1:0] sel_s = sync_out[4:3];

	// history of synchronised levels for edge detection
	logic scl_p_q;
	logic sda_p_q;
	logic tgl_p_q;

	// reset matches the synchroniser's, so its fill after reset
	// shows no false fall, start or stop
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			scl_p_q <= 1'h0;
			sda_p_q <= 1'h0;
			tgl_p_q <= 1'h0;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
			tgl_p_q <= tgl_s;
		end
	end

	// bus conditions and bit events
	wire start_det = scl_s & scl_p_q & sda_p_q & ~sda_s;
	wire stop_det = scl_s & scl_p_q & ~sda_p_q & sda_s;
	wire rise_ev = tgl_s ^ tgl_p_q;
	wire fall_ev = scl_p_q & ~scl_s;
	wire bit_in = link_bit_q;

	// transaction state
	iox_pkg::iox_state_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d;
	logic [7:0] tx_q, tx_d;
	logic [2:0] ptr_q, ptr_d;
	logic cmd_valid_q, cmd_valid_d;
	logic ack_q, ack_d;
	logic rw_q, rw_d;
	logic oe_q, oe_d;
	logic wr_stb_q, wr_stb_d;
	logic [7:0] wr_data_q, wr_data_d;
	logic rd_stb_q, rd_stb_d;
	logic sda_o_q;

	// byte boundary decodes
	wire data_bit = cnt_q < iox_pkg::BIT_ACK;
	wire last_bit = rise_ev & (cnt_q == iox_pkg::BIT_LAST);
	wire ack_rise = rise_ev & (cnt_q == iox_pkg::BIT_ACK);
	wire [7:0] byte_in = {sh_q[6:0], bit_in};
	wire [6:0] my_addr = {iox_pkg::ADDR_FIXED, sel_s};
	wire addr_hit = byte_in[7:1] == my_addr; // R12
	wire is_read = byte_in[0] == iox_pkg::RW_READ; // R12
	wire [2:0] ptr_pair = {ptr_q[2:1], ~ptr_q[0]};
	wire [2:0] tx_idx = 3'(iox_pkg::BIT_LAST - cnt_q);
	wire master_ack = ~bit_in;

	// next-state decode of the transaction
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ptr_d = ptr_q;
		cmd_valid_d = cmd_valid_q;
		ack_d = ack_q;
		rw_d = rw_q;
		oe_d = oe_q;
		wr_stb_d = 1'h0;
		wr_data_d = wr_data_q;
		rd_stb_d = 1'h0;
		if (start_det) begin
			// repeated start keeps ptr as it stands
			st_d = iox_pkg::ST_ADDR; // R16 R8
			cnt_d = 4'h0;
			ack_d = 1'h0;
			oe_d = 1'h0;
		end else if (stop_det) begin
			// written bytes already applied stay valid
			st_d = iox_pkg::ST_IDLE; // R16 R10
			cnt_d = 4'h0;
			ack_d = 1'h0;
			oe_d = 1'h0;
		end else if (rise_ev && data_bit) begin
			sh_d = byte_in;
			cnt_d = cnt_q + 4'h1;
			if (last_bit) begin
				case (st_q)
					iox_pkg::ST_ADDR: begin
						rw_d = byte_in[0];
						if (addr_hit && (!is_read || cmd_valid_q)) begin
							ack_d = 1'h1; // R1 R2
						end else begin
							// foreign address, or read before command
							st_d = iox_pkg::ST_IGNORE; // R4
						end
					end
					iox_pkg::ST_CMD: begin
						ptr_d = byte_in[2:0]; // R13 R14
						cmd_valid_d = 1'h1; // R4
						ack_d = 1'h1; // R1
					end
					iox_pkg::ST_WDATA: begin
						wr_stb_d = 1'h1; // R1
						wr_data_d = byte_in;
						ptr_d = ptr_pair; // R15
						ack_d = 1'h1;
					end
					default: begin
						ack_d = 1'h0;
					end
				endcase
			end
		end else if (ack_rise) begin
			cnt_d = 4'h0;
			ack_d = 1'h0;
			case (st_q)
				iox_pkg::ST_ADDR: begin
					if (rw_q == iox_pkg::RW_READ) begin
						// served from current ptr, no command needed
						tx_d = REG_RD_DATA; // R6 R5 R11
						rd_stb_d = 1'h1;
						ptr_d = ptr_pair; // R7
						st_d = iox_pkg::ST_RDATA; // R2
					end else begin
						st_d = iox_pkg::ST_CMD; // R1
					end
				end
				iox_pkg::ST_CMD: begin
					st_d = iox_pkg::ST_WDATA;
				end
				iox_pkg::ST_RDATA: begin
					if (master_ack) begin
						tx_d = REG_RD_DATA; // R6 R9
						rd_stb_d = 1'h1;
						ptr_d = ptr_pair; // R7 R9
					end else begin
						// nack ends the read; wait for stop or start
						st_d = iox_pkg::ST_IGNORE; // R3
					end
				end
				default: begin
					st_d = st_q;
				end
			endcase
		end else if (fall_ev) begin
			// open drain: enable pulls low, release lets it float high
			if (ack_q && cnt_q == iox_pkg::BIT_ACK) begin
				oe_d = 1'h1;
			end else if (st_q == iox_pkg::ST_RDATA && data_bit) begin
				oe_d = ~tx_q[tx_idx];
			end else begin
				oe_d = 1'h0;
			end
		end
	end

	// state registers
	always_ff @(posedge REF_CLK or posedge RST) begin
		if (RST) begin
			st_q <= iox_pkg::ST_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'h00;
			ptr_q <= iox_pkg::PTR_RESET;
			cmd_valid_q <= 1'h0;
			ack_q <= 1'h0;
			rw_q <= iox_pkg::RW_WRITE;
			oe_q <= 1'h0;
			wr_stb_q <= 1'h0;
			wr_data_q <= 8'h00;
			rd_stb_q <= 1'h0;
			sda_o_q <= 1'h0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ptr_q <= ptr_d;
			cmd_valid_q <= cmd_valid_d;
			ack_q <= ack_d;
			rw_q <= rw_d;
			oe_q <= oe_d;
			wr_stb_q <= wr_stb_d;
			wr_data_q <= wr_data_d;
			rd_stb_q <= rd_stb_d;
			sda_o_q <= 1'h0; // line only ever pulled low
		end
	end

	// outputs, all straight from flip-flops
	assign SDA_O = sda_o_q;
	assign SDA_OE = oe_q;
	assign REG_PTR = ptr_q;
	assign REG_WR_STB = wr_stb_q;
	assign REG_WR_DATA = wr_data_q;
	assign REG_RD_STB = rd_stb_q;
	assign CMD_VALID = cmd_valid_q;
endmodule
`default_nettype wire

//--- verification/iox_i2c_target_props.sv
// register-side assertions of the i2c target
// assumes it is bound onto iox_i2c_target
`timescale 1ns/1ps
`default_nettype none
module iox_i2c_target_props (
	input wire logic REF_CLK,
	input wire logic RST,
	input wire logic [2:0] REG_PTR,
	input wire logic REG_WR_STB,
	input wire logic [7:0] REG_WR_DATA,
	input wire logic REG_RD_STB,
	input wire logic CMD_VALID
);
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// every strobed data byte moves to the partner register
	a_wr_toggle: assert property (REG_WR_STB |-> REG_PTR == ($past(REG_PTR) ^ 3'h1))
		else $error("write kept pointer");
	a_rd_toggle: assert property (REG_RD_STB |-> REG_PTR == ($past(REG_PTR) ^ 3'h1))
		else $error("read kept pointer");
	// no capture until a command byte was taken
	a_rd_nocmd: assert property (!CMD_VALID |-> !REG_RD_STB)
		else $error("read before command");
	a_wr_nocmd: assert property (REG_WR_STB |-> CMD_VALID)
		else $error("write before command");
	a_cmd_sticky: assert property ($past(CMD_VALID) |-> CMD_VALID)
		else $error("command lost");
	// strobes are at least nine core clocks apart
	a_rd_space: assert property (REG_RD_STB |=> !REG_RD_STB [*8])
		else $error("read strobes too close");
	a_wr_space: assert property (REG_WR_STB |=> !REG_WR_STB [*8])
		else $error("write strobes too close");
	a_wdata_hold: assert property (!REG_WR_STB |-> $stable(REG_WR_DATA))
		else $error("write data moved");
endmodule
bind iox_i2c_target iox_i2c_target_props u_iox_i2c_target_props (.REF_CLK(REF_CLK),
	.RST(RST), .REG_PTR(REG_PTR), .REG_WR_STB(REG_WR_STB), .REG_WR_DATA(REG_WR_DATA),
	.REG_RD_STB(REG_RD_STB), .CMD_VALID(CMD_VALID));
`default_nettype wire

//--- verification/iox_ctl_model.sv
// i2c bus controller model, open drain on sda
// assumes a pull-up on sda; scl stands high between frames
`timescale 1ns/1ps
`default_nettype none
module iox_ctl_model (
	output logic scl,
	output logic sda_low,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// start or repeated start; 64 ns link period, edges land between core rises
	task automatic start();
		sda_low = 1'b0;
		#32 scl = 1'b1;
		#32 sda_low = 1'b1;
		#32 scl = 1'b0;
	endtask
	task automatic stop();
		sda_low = 1'b1;
		#32 scl = 1'b1;
		#32 sda_low = 1'b0;
		#32;
	endtask
	// sda only changes while scl is low
	task automatic bitx(input logic b, output logic r);
		sda_low = !b;
		#32 scl = 1'b1;
		#16 r = sda;
		#16 scl = 1'b0;
	endtask
	// ninth bit released for writes, ack or nack for reads
	task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
		output logic got);
		for (int i = 7; i >= 0; i--) bitx(tx[i], rx[i]);
		bitx(nine, got);
	endtask
endmodule
`default_nettype wire

//--- verification/test_io_expander_i2c_register_access.sv
// testbench: controller model on the bus, register file beside the target
// assumes a pull-up on sda; select pins driven, normally address 1110110
`timescale 1ns/1ps
`default_nettype none
module test_io_expander_i2c_register_access;
	logic ref_clk = 1'b1;
	logic rst = 1'b0;
	logic sel_hi = 1'b1;
	logic sel_lo = 1'b0;
	int rd_count = 0;
	logic scl, ctl_low, sda_oe, sda_o, wr_stb, rd_stb, cmd_valid, got;
	logic [2:0] ptr, wr_p;
	logic [7:0] wr_data, wr_q, rx;
	int fail_count = 0;
	int comparisons = 0;
	wire sda = !(ctl_low || sda_oe); // pulled up unless someone sinks it
	wire [7:0] rd_data = 8'ha0 + 8'(ptr); // register file answers from pointer
	always #2 ref_clk = ~ref_clk;
	iox_i2c_target u_iox_i2c_target (.REF_CLK(ref_clk), .RST(rst), .SCL_CLK(scl),
		.SDA_I(sda), .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_SELECT_LOW(sel_lo),
		.ADDR_SELECT_HIGH(sel_hi), .REG_PTR(ptr), .REG_WR_STB(wr_stb), .REG_WR_DATA(wr_data),
		.REG_RD_STB(rd_stb), .REG_RD_DATA(rd_data), .CMD_VALID(cmd_valid));
	iox_ctl_model u_iox_ctl_model (.scl(scl), .sda_low(ctl_low), .sda(sda));
	// latch the last write handed to the register file
	always @(posedge ref_clk) if (wr_stb) begin
		wr_q <= wr_data;
		wr_p <= ptr ^ 3'h1;
	end
	// count read captures handed to the register file
	always @(posedge ref_clk) if (rd_stb) rd_count <= rd_count + 1;
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// write a byte, expect ack (0) or nack (1)
	task automatic wb(input logic [7:0] b, input logic n);
		u_iox_ctl_model.xfer(b, 1'b1, rx, got);
		check({7'h0, got}, {7'h0, n});
	endtask
	// read a byte, then ack (0) or nack (1)
	task automatic rb(input logic n, input logic [7:0] exp);
		u_iox_ctl_model.xfer(8'hff, n, rx, got);
		check(rx, exp);
	endtask
	task automatic t_refuse();
		u_iox_ctl_model.start();
		wb(8'hee, 1'b1);
		u_iox_ctl_model.start();
		wb(8'hed, 1'b1);
		u_iox_ctl_model.stop();
		check({7'h0, cmd_valid}, 8'h0);
		// move the low select pin: the other address now answers
		sel_lo = 1'b1;
		u_iox_ctl_model.start();
		wb(8'hee, 1'b0);
		u_iox_ctl_model.stop();
		sel_lo = 1'b0;
		check({7'h0, cmd_valid}, 8'h0);
		$display("test refuse done");
	endtask
	task automatic t_write();
		u_iox_ctl_model.start();
		wb(8'hec, 1'b0);
		wb(8'h02, 1'b0);
		wb(8'h5a, 1'b0);
		check(wr_q, 8'h5a);
		check({5'h0, wr_p}, 8'h02);
		wb(8'hc3, 1'b0);
		check({wr_q[3:0], 1'b0, wr_p}, 8'h33);
		u_iox_ctl_model.stop();
		check({7'h0, cmd_valid}, 8'h01);
		$display("test write done");
	endtask
	task automatic t_read();
		u_iox_ctl_model.start();
		wb(8'hec, 1'b0);
		wb(8'h07, 1'b0);
		u_iox_ctl_model.start();
		wb(8'hed, 1'b0);
		rb(1'b0, 8'ha7);
		rb(1'b0, 8'ha6);
		rb(1'b1, 8'ha7);
		u_iox_ctl_model.stop();
		check(8'(rd_count), 8'h03);
		check({6'h0, sda_o, sda_oe}, 8'h00);
		$display("test read done");
	endtask
	task automatic t_restart();
		u_iox_ctl_model.start();
		wb(8'hed, 1'b0);
		rb(1'b0, 8'ha6);
		u_iox_ctl_model.start();
		wb(8'hed, 1'b0);
		rb(1'b1, 8'ha6);
		u_iox_ctl_model.stop();
		check(8'(rd_count), 8'h06);
		$display("test restart done");
	endtask
	// watchdog against a hang
	initial begin
		repeat (20000) @(posedge ref_clk);
		fail_count++;
		conclude();
	end
	// a real reset edge reaches both clock domains
	initial begin
		@(negedge ref_clk) rst = 1'b1;
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk) rst = 1'b0;
		repeat (8) @(negedge ref_clk);
		t_refuse();
		t_write();
		t_read();
		t_restart();
		conclude();
	end
endmodule
`default_nettype wire
